// ### hw/talkback_map.svh
// Register offsets, gain encoding, reset values and timing counts of the talkback/headphone block
//----------------------------------------------------------------
// Behaviour
//----------------------------------------------------------------
// Behaviour
// - Talkback 1 LED lit exactly while talkback output 1 is active.
// - On-air mode: talkback 1 active mutes main output; production mode: no effect.
// - Push-to-talk: talkback 1 rests muted, active only while button held.
// - Hybrid: hold gives active until release; a tap toggles the latched state.
// - Talkback output 1 is muted after power-up.
// - Talkback 2 enabled: its LED lit exactly while talkback output 2 active.
// - Talkback 2 disabled: LED lit only if aux relay follows button 2.
// - On-air mode: talkback 2 active mutes main output; production mode: no effect.
// - Push-to-talk: talkback 2 rests muted, active while held only when enabled.
// - Hybrid and enabled: hold active until release; tap toggles latched state.
// - Talkback output 2 is muted after power-up.
// - Level/level normal: left pot sets left channel, right pot right channel.
// - Level/level reversed: left pot sets right channel, right pot left.
// - Level/level with floor: fully counterclockwise gives 40 dB below maximum.
// - Level/level with full mute: fully counterclockwise mutes that channel.
// - Level/balance: left pot sets overall gain, right pot sets balance.
// - Balance normal: counterclockwise reduces the right channel gain.
// - Balance reversed: counterclockwise reduces the left channel gain.
// - Floor: level minimum puts both 40 dB down; balance extreme that channel.
// - Full mute: level minimum mutes both; balance extreme mutes that channel.
// - Balance at midpoint gives equal gain on left and right.
`ifndef TALKBACK_MAP_SVH
`define TALKBACK_MAP_SVH

//----------------------------------------------------------------
// Register map
//----------------------------------------------------------------
`define REG_CTRL_OFS      12'h000
`define REG_STATUS_OFS    12'h004
`define REG_POTS_OFS      12'h008
`define CTRL_RESET        8'h00
`define CTRL_W            8

//----------------------------------------------------------------
// Gain encoding, attenuation in dB
//----------------------------------------------------------------
`define HP_FLOOR_DB       8'h28
`define HP_ATTEN_MUTE     8'hff
`define POT_MIN           8'h00
`define POT_MAX           8'hff
`define POT_MID           8'h80

//----------------------------------------------------------------
// Timing
//----------------------------------------------------------------
`define CLK_HZ            25000000
`define TB_DEBOUNCE_MS    20
`define TB_HOLD_MS        500
`define POT_SAMPLE_MS     1
`define TB_DEBOUNCE_CYC   ((`CLK_HZ / 1000) * `TB_DEBOUNCE_MS)
`define TB_HOLD_CYC       ((`CLK_HZ / 1000) * `TB_HOLD_MS)
`define POT_SAMPLE_CYC    ((`CLK_HZ / 1000) * `POT_SAMPLE_MS)

`endif

// ### hw/talkback_pkg.sv
// Types of the talkback/headphone block
package talkback_pkg;

	typedef enum logic [2:0]
	{
		BTN_IDLE  = 3'b001,
		BTN_PRESS = 3'b010,
		BTN_HOLD  = 3'b100
	} btn_fsm_t;

	typedef struct packed
	{
		logic full_mute;
		logic reverse;
		logic balance_mode;
		logic aux_follow_tb2;
		logic tb2_enable;
		logic tb2_hybrid;
		logic tb1_hybrid;
		logic on_air;
	} ctrl_t;

	typedef struct packed
	{
		logic [1:0]  sync;
		logic        stable;
		logic [23:0] db_cnt;
		btn_fsm_t    fsm;
		logic [23:0] hold_cnt;
		logic        latch;
	} btn_t;

	typedef struct packed
	{
		ctrl_t          ctrl;
		btn_t [1:0]     btn;
		logic [1:0]     tb_active;
		logic [1:0]     led;
		logic           main_mute;
		logic [7:0]     pot_l_meta;
		logic [7:0]     pot_l_sync;
		logic [7:0]     pot_r_meta;
		logic [7:0]     pot_r_sync;
		logic [23:0]    smp_cnt;
		logic [7:0]     pot_l;
		logic [7:0]     pot_r;
		logic [7:0]     atten_l;
		logic [7:0]     atten_r;
		logic [31:0]    prdata;
		logic           pslverr;
	} state_t;

endpackage : talkback_pkg

// ### hw/talkback_ctrl.sv
// Talkback buttons, LEDs, main-output mute and headphone gain logic with APB registers
`include "talkback_map.svh"

module talkback_ctrl
#(
	parameter int unsigned DEBOUNCE_CYCLES = `TB_DEBOUNCE_CYC,
	parameter int unsigned HOLD_CYCLES     = `TB_HOLD_CYC,
	parameter int unsigned SAMPLE_CYCLES   = `POT_SAMPLE_CYC
)
(
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	input  wire logic        BTN_TB1_IN,
	input  wire logic        BTN_TB2_IN,
	input  wire logic [7:0]  POT_LEFT_IN,
	input  wire logic [7:0]  POT_RIGHT_IN,
	output logic             TB1_ACTIVE_OUT,
	output logic             TB2_ACTIVE_OUT,
	output logic             LED_TB1_OUT,
	output logic             LED_TB2_OUT,
	output logic             MAIN_MUTE_OUT,
	output logic      [7:0]  ATTEN_LEFT_OUT,
	output logic      [7:0]  ATTEN_RIGHT_OUT
);

	//----------------------------------------------------------------
	// Gain arithmetic
	//----------------------------------------------------------------
	// Level pot to attenuation: linear 0..floor dB, minimum end may mute
	function automatic logic [7:0] level_atten(input logic [7:0] pot, input logic mute);
		logic [15:0] prod;
		prod = 16'(`POT_MAX - pot) * 16'(`HP_FLOOR_DB);
		if (mute && (pot == `POT_MIN))
		begin
			return `HP_ATTEN_MUTE;
		end
		return 8'(prod / 16'(`POT_MAX));
	endfunction : level_atten

	// Cut on the channel that loses level when balance turns counterclockwise
	function automatic logic [7:0] bal_ccw_cut(input logic [7:0] pot, input logic mute);
		logic [15:0] prod;
		prod = 16'(`POT_MID - pot) * 16'(`HP_FLOOR_DB);
		if (pot >= `POT_MID)
		begin
			return 8'h00;
		end
		if (mute && (pot == `POT_MIN))
		begin
			return `HP_ATTEN_MUTE;
		end
		return 8'(prod / 16'(`POT_MID));
	endfunction : bal_ccw_cut

	// Cut on the channel that loses level when balance turns clockwise
	function automatic logic [7:0] bal_cw_cut(input logic [7:0] pot, input logic mute);
		logic [15:0] prod;
		prod = 16'(pot - `POT_MID) * 16'(`HP_FLOOR_DB);
		if (pot <= `POT_MID)
		begin
			return 8'h00;
		end
		if (mute && (pot == `POT_MAX))
		begin
			return `HP_ATTEN_MUTE;
		end
		return 8'(prod / 16'(`POT_MAX - `POT_MID));
	endfunction : bal_cw_cut

	// Sum of two cuts, held at the floor unless either one mutes
	function automatic logic [7:0] add_atten(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		if ((a == `HP_ATTEN_MUTE) || (b == `HP_ATTEN_MUTE))
		begin
			return `HP_ATTEN_MUTE;
		end
		if (sum > {1'b0, `HP_FLOOR_DB})
		begin
			return `HP_FLOOR_DB;
		end
		return sum[7:0];
	endfunction : add_atten

	//----------------------------------------------------------------
	// State
	//----------------------------------------------------------------
	talkback_pkg::state_t r_reg;
	talkback_pkg::state_t r_next;

	logic        apb_setup;
	logic        apb_write;
	logic [1:0]  btn_pin;
	logic [1:0]  btn_en;
	logic [1:0]  btn_hybrid;
	logic        pressed;
	logic        smp_tick;
	logic [7:0]  level_cut;
	logic [7:0]  ccw_cut;
	logic [7:0]  cw_cut;
	logic [7:0]  lvl_l;
	logic [7:0]  lvl_r;

	assign apb_setup = PSEL_IN && !PENABLE_IN;
	assign apb_write = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign btn_pin   = {BTN_TB2_IN, BTN_TB1_IN};

	//----------------------------------------------------------------
	// Next-state logic
	//----------------------------------------------------------------
	always_comb
	begin
		r_next     = r_reg;
		pressed    = 1'b0;
		btn_en     = {r_reg.ctrl.tb2_enable, 1'b1};
		btn_hybrid = {r_reg.ctrl.tb2_hybrid, r_reg.ctrl.tb1_hybrid};
		smp_tick   = (r_reg.smp_cnt == 24'(SAMPLE_CYCLES - 1));
		level_cut  = 8'h00;
		ccw_cut    = 8'h00;
		cw_cut     = 8'h00;
		lvl_l      = 8'h00;
		lvl_r      = 8'h00;

		// Control register write, taken in the access phase
		if (apb_write && (PADDR_IN == `REG_CTRL_OFS))
		begin
			r_next.ctrl = talkback_pkg::ctrl_t'(PWDATA_IN[`CTRL_W-1:0]);
		end

		// Buttons: synchronise, debounce, then tap/hold state machine
		for (int i = 0; i < 2; i++)
		begin
			r_next.btn[i].sync = {r_reg.btn[i].sync[0], btn_pin[i]};
			if (r_reg.btn[i].sync[1] != r_reg.btn[i].stable)
			begin
				if (r_reg.btn[i].db_cnt == 24'(DEBOUNCE_CYCLES - 1))
				begin
					r_next.btn[i].stable = r_reg.btn[i].sync[1];
					r_next.btn[i].db_cnt = 24'h000000;
				end
				else
				begin
					r_next.btn[i].db_cnt = r_reg.btn[i].db_cnt + 24'h000001;
				end
			end
			else
			begin
				r_next.btn[i].db_cnt = 24'h000000;
			end

			pressed = r_reg.btn[i].stable;
			case (r_reg.btn[i].fsm)
				talkback_pkg::BTN_IDLE:
				begin
					if (pressed && btn_en[i])
					begin
						r_next.btn[i].fsm      = talkback_pkg::BTN_PRESS;
						r_next.btn[i].hold_cnt = 24'h000000;
					end
				end
				talkback_pkg::BTN_PRESS:
				begin
					if (!pressed)
					begin
						r_next.btn[i].fsm = talkback_pkg::BTN_IDLE;
						if (btn_hybrid[i])
						begin
							r_next.btn[i].latch = !r_reg.btn[i].latch;
						end
					end
					else if (r_reg.btn[i].hold_cnt == 24'(HOLD_CYCLES - 1))
					begin
						r_next.btn[i].fsm = talkback_pkg::BTN_HOLD;
					end
					else
					begin
						r_next.btn[i].hold_cnt = r_reg.btn[i].hold_cnt + 24'h000001;
					end
				end
				talkback_pkg::BTN_HOLD:
				begin
					if (!pressed)
					begin
						r_next.btn[i].fsm   = talkback_pkg::BTN_IDLE;
						r_next.btn[i].latch = 1'b0;
					end
				end
				default:
				begin
					r_next.btn[i].fsm = talkback_pkg::BTN_IDLE;
				end
			endcase

			// Push-to-talk never latches; a disabled function stays muted
			if (!btn_hybrid[i] || !btn_en[i])
			begin
				r_next.btn[i].latch = 1'b0;
			end
			if (!btn_en[i])
			begin
				r_next.btn[i].fsm = talkback_pkg::BTN_IDLE;
			end
			r_next.tb_active[i] = (r_next.btn[i].fsm != talkback_pkg::BTN_IDLE) || r_next.btn[i].latch;
		end

		r_next.led[0] = r_next.tb_active[0];
		if (r_reg.ctrl.tb2_enable)
		begin
			r_next.led[1] = r_next.tb_active[1];
		end
		else
		begin
			r_next.led[1] = r_reg.ctrl.aux_follow_tb2 && r_reg.btn[1].stable;
		end
		r_next.main_mute = r_reg.ctrl.on_air && (r_next.tb_active != 2'b00);

		// Pots: synchronise, sample each period, recompute gains
		r_next.pot_l_meta = POT_LEFT_IN;
		r_next.pot_l_sync = r_reg.pot_l_meta;
		r_next.pot_r_meta = POT_RIGHT_IN;
		r_next.pot_r_sync = r_reg.pot_r_meta;
		if (smp_tick)
		begin
			r_next.smp_cnt = 24'h000000;
			r_next.pot_l   = r_reg.pot_l_sync;
			r_next.pot_r   = r_reg.pot_r_sync;
		end
		else
		begin
			r_next.smp_cnt = r_reg.smp_cnt + 24'h000001;
		end

		if (r_reg.ctrl.balance_mode)
		begin
			level_cut = level_atten(r_reg.pot_l, r_reg.ctrl.full_mute);
			ccw_cut   = bal_ccw_cut(r_reg.pot_r, r_reg.ctrl.full_mute);
			cw_cut    = bal_cw_cut(r_reg.pot_r, r_reg.ctrl.full_mute);
			if (r_reg.ctrl.reverse)
			begin
				lvl_l = add_atten(level_cut, ccw_cut);
				lvl_r = add_atten(level_cut, cw_cut);
			end
			else
			begin
				lvl_l = add_atten(level_cut, cw_cut);
				lvl_r = add_atten(level_cut, ccw_cut);
			end
		end
		else if (r_reg.ctrl.reverse)
		begin
			lvl_l = level_atten(r_reg.pot_r, r_reg.ctrl.full_mute);
			lvl_r = level_atten(r_reg.pot_l, r_reg.ctrl.full_mute);
		end
		else
		begin
			lvl_l = level_atten(r_reg.pot_l, r_reg.ctrl.full_mute);
			lvl_r = level_atten(r_reg.pot_r, r_reg.ctrl.full_mute);
		end
		if (smp_tick)
		begin
			r_next.atten_l = lvl_l;
			r_next.atten_r = lvl_r;
		end

		// Read data and error prepared in the setup phase
		if (apb_setup)
		begin
			r_next.prdata  = 32'h00000000;
			r_next.pslverr = 1'b0;
			if (PADDR_IN == `REG_CTRL_OFS)
			begin
				r_next.prdata[`CTRL_W-1:0] = r_reg.ctrl;
			end
			else if (PADDR_IN == `REG_STATUS_OFS)
			begin
				r_next.prdata = {8'h00, r_reg.atten_r, r_reg.atten_l, 3'b000,
					r_reg.led, r_reg.main_mute, r_reg.tb_active};
			end
			else if (PADDR_IN == `REG_POTS_OFS)
			begin
				r_next.prdata = {16'h0000, r_reg.pot_r, r_reg.pot_l};
			end
			else
			begin
				r_next.pslverr = 1'b1;
			end
		end
	end

	//----------------------------------------------------------------
	// State register
	//----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			r_reg            <= '0;
			r_reg.ctrl       <= talkback_pkg::ctrl_t'(`CTRL_RESET);
			r_reg.btn[0].fsm <= talkback_pkg::BTN_IDLE;
			r_reg.btn[1].fsm <= talkback_pkg::BTN_IDLE;
			r_reg.atten_l    <= `HP_ATTEN_MUTE;
			r_reg.atten_r    <= `HP_ATTEN_MUTE;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	//----------------------------------------------------------------
	// Outputs
	//----------------------------------------------------------------
	assign PRDATA_OUT      = r_reg.prdata;
	assign PREADY_OUT      = 1'b1;
	assign PSLVERR_OUT     = r_reg.pslverr && PSEL_IN && PENABLE_IN;
	assign TB1_ACTIVE_OUT  = r_reg.tb_active[0];
	assign TB2_ACTIVE_OUT  = r_reg.tb_active[1];
	assign LED_TB1_OUT     = r_reg.led[0];
	assign LED_TB2_OUT     = r_reg.led[1];
	assign MAIN_MUTE_OUT   = r_reg.main_mute;
	assign ATTEN_LEFT_OUT  = r_reg.atten_l;
	assign ATTEN_RIGHT_OUT = r_reg.atten_r;

endmodule : talkback_ctrl

// ### testbench/talkback_ctrl_monitor.sv
// Port checks of the talkback and headphone block
module talkback_ctrl_monitor
(
	input wire logic        CLK_SYS_IN,
	input wire logic        RST_N_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        TB1_ACTIVE_OUT,
	input wire logic        TB2_ACTIVE_OUT,
	input wire logic        LED_TB1_OUT,
	input wire logic        LED_TB2_OUT,
	input wire logic        MAIN_MUTE_OUT,
	input wire logic [7:0]  ATTEN_LEFT_OUT
);
	//----
	// Shadow of the control register
	//----
	talkback_pkg::ctrl_t ctrl_reg;
	wire logic           tb_any;
	assign tb_any = TB1_ACTIVE_OUT | TB2_ACTIVE_OUT;
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			ctrl_reg <= '0;
		else if (PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 12'h000)
			ctrl_reg <= PWDATA_IN[7:0];
	end
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RST_N_IN);
	led_one_a: assert property (LED_TB1_OUT == TB1_ACTIVE_OUT)
		else $error("led 1 differs from talkback 1");
	main_mute_a: assert property ($stable(ctrl_reg) |-> MAIN_MUTE_OUT == (ctrl_reg.on_air & tb_any))
		else $error("main mute wrong");
	tb2_off_a: assert property ($stable(ctrl_reg) && !ctrl_reg.tb2_enable |-> !TB2_ACTIVE_OUT)
		else $error("talkback 2 active while disabled");
	led_two_a: assert property ($stable(ctrl_reg) && ctrl_reg.tb2_enable |-> LED_TB2_OUT == TB2_ACTIVE_OUT)
		else $error("led 2 differs from talkback 2");
	led_aux_a: assert property ($stable(ctrl_reg) && ctrl_reg == 8'h00 |-> !LED_TB2_OUT)
		else $error("led 2 lit without aux follow");
	floor_a: assert property ($changed(ATTEN_LEFT_OUT) && $stable(ctrl_reg) && !ctrl_reg.full_mute
		|-> ATTEN_LEFT_OUT <= 8'h28)
		else $error("left channel below floor");
	atten_range_a: assert property (ATTEN_LEFT_OUT <= 8'h28 || ATTEN_LEFT_OUT == 8'hff)
		else $error("left attenuation out of range");
	apb_ready_a: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
		else $error("no ready in access");
	apb_error_a: assert property (PSLVERR_OUT == (PSEL_IN && PENABLE_IN
		&& !(PADDR_IN inside {12'h000, 12'h004, 12'h008})))
		else $error("slave error wrong");
	reset_out_a: assert property (disable iff (1'b0) !RST_N_IN |-> ATTEN_LEFT_OUT == 8'hff && !tb_any)
		else $error("outputs not at reset values");
	cover property ($rose(MAIN_MUTE_OUT));
	cover property ($rose(LED_TB2_OUT) && !TB2_ACTIVE_OUT);
	cover property (PSLVERR_OUT);
endmodule : talkback_ctrl_monitor

bind talkback_ctrl talkback_ctrl_monitor talkback_ctrl_monitor_inst (.*);

// ### testbench/front_panel.sv
// Front panel model: buttons with contact chatter and pot positions
module front_panel
(
	input  wire logic       clk_in,
	input  wire logic [1:0] press_in,
	input  wire logic [7:0] pot_l_in,
	input  wire logic [7:0] pot_r_in,
	output logic      [1:0] btn_out = '0,
	output logic      [7:0] pot_l_out = '0,
	output logic      [7:0] pot_r_out = 8'h80
);
	logic [1:0] last_reg = '0;
	logic [1:0] chg_reg = '0;
	logic [2:0] bounce_reg = '0;
	// A changed button chatters for a few cycles before it settles
	always @(posedge clk_in)
	begin
		last_reg <= press_in;
		if (press_in != last_reg)
		begin
			chg_reg <= press_in ^ last_reg;
			bounce_reg <= 3'h5;
		end
		else
			bounce_reg <= bounce_reg >> 1;
		btn_out <= press_in ^ (chg_reg & {2{bounce_reg[0]}});
		pot_l_out <= pot_l_in;
		pot_r_out <= pot_r_in;
	end
endmodule : front_panel

// ### testbench/talkback_ctrl_tb.sv
// Self-checking bench of the talkback and headphone block
module talkback_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [1:0]  press = '0;
	logic [7:0]  pl = '0;
	logic [7:0]  pr = 8'h80;
	logic [31:0] rd;
	logic        er;
	int          errors = 0;
	int          check_count = 0;
	wire logic [1:0]  btn;
	wire logic [7:0]  pot_l, pot_r, al, ar;
	wire logic [31:0] prdata;
	wire logic        pready, pslverr, t1, t2, l1, l2, mm;
	wire logic [2:0]  s1, s2;
	assign s1 = {mm, l1, t1};
	assign s2 = {mm, l2, t2};
	// Entries: ctrl, left pot, right pot, right atten, left atten
	logic [39:0] tbl [10] = '{40'h0000ff0028, 40'h8000ff00ff, 40'h4000ff2800, 40'h20ff002800, 40'h60ff000028,
		40'ha0ff00ff00, 40'h2000802828, 40'ha00080ffff, 40'h20ff800000, 40'h0080401d13};
	logic [7:0]  c2 [3] = '{8'h01, 8'h11, 8'h09};
	logic [2:0]  e2 [3] = '{3'h0, 3'h2, 3'h7};

	front_panel front_panel_inst (.clk_in(clk), .press_in(press), .pot_l_in(pl), .pot_r_in(pr),
		.btn_out(btn), .pot_l_out(pot_l), .pot_r_out(pot_r));

	talkback_ctrl #(.DEBOUNCE_CYCLES(4), .HOLD_CYCLES(40), .SAMPLE_CYCLES(8)) talkback_ctrl_inst
	(
		.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .BTN_TB1_IN(btn[0]), .BTN_TB2_IN(btn[1]), .POT_LEFT_IN(pot_l),
		.POT_RIGHT_IN(pot_r), .TB1_ACTIVE_OUT(t1), .TB2_ACTIVE_OUT(t2), .LED_TB1_OUT(l1),
		.LED_TB2_OUT(l2), .MAIN_MUTE_OUT(mm), .ATTEN_LEFT_OUT(al), .ATTEN_RIGHT_OUT(ar)
	);

	//----
	// Tasks
	//----
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic ac(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : ac

	task automatic push(input int i, input logic v, input int n);
		@(posedge clk);
		press[i] <= v;
		repeat (n) @(posedge clk);
	endtask : push

	initial
	begin
		forever #20 clk = ~clk;
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		end_of_test();
	end

	initial
	begin
		// A real falling edge, so the asynchronous reset takes hold before the first clock
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		ac(1'b0, 12'h004, '0);
		chk(rd, 32'h00ffff00);
		ac(1'b0, 12'h00c, '0);
		chk({rd[30:0], er}, 32'h1);
		ac(1'b1, 12'h000, 32'h01);
		push(0, 1'b1, 16);
		chk(s1, 32'h7);
		push(0, 1'b0, 16);
		chk(s1, 32'h0);
		ac(1'b1, 12'h000, 32'h00);
		push(0, 1'b1, 16);
		chk(s1, 32'h3);
		push(0, 1'b0, 16);
		for (int k = 0; k < 3; k++)
		begin
			ac(1'b1, 12'h000, {24'h0, c2[k]});
			push(1, 1'b1, 16);
			chk(s2, e2[k]);
			push(1, 1'b0, 16);
			chk(s2, 32'h0);
		end
		for (int i = 0; i < 2; i++)
		begin
			ac(1'b1, 12'h000, i ? 32'h0d : 32'h03);
			for (int k = 0; k < 2; k++)
			begin
				push(i, 1'b1, 16);
				push(i, 1'b0, 16);
				chk(i ? s2 : s1, k ? 32'h0 : 32'h7);
			end
		end
		ac(1'b1, 12'h000, 32'h03);
		push(0, 1'b1, 80);
		chk(s1, 32'h7);
		push(0, 1'b0, 16);
		chk(s1, 32'h0);
		for (int k = 0; k < 10; k++)
		begin
			ac(1'b1, 12'h000, {24'h0, tbl[k][39:32]});
			pl <= tbl[k][31:24];
			pr <= tbl[k][23:16];
			repeat (30) @(posedge clk);
			ac(1'b0, 12'h004, '0);
			chk(rd[23:8], tbl[k][15:0]);
			chk({ar, al}, tbl[k][15:0]);
			ac(1'b0, 12'h008, '0);
			chk(rd, {16'h0000, tbl[k][23:16], tbl[k][31:24]});
			ac(1'b0, 12'h000, '0);
			chk(rd, {24'h000000, tbl[k][39:32]});
		end
		end_of_test();
	end
endmodule : talkback_ctrl_tb
